// *** bench/cltd_decoder_sva.sv ***
// assertion checker for the instruction decoder
`timescale 1ns/100ps
`default_nettype none
module cltd_decoder_sva (
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic instr_valid, // word offered
  input wire logic [15:0] instr, // program word
  input wire logic flag_z, // zero
  input wire logic flag_c, // carry
  input wire logic flag_ov, // overflow
  input wire logic flag_n, // negative
  input wire logic nvm_done, // write ended
  input wire logic busy_q, // nop cycle
  input wire logic pc_rel_q, // relative jump
  input wire logic pc_abs_q, // absolute jump
  input wire logic [19:0] pc_abs_addr_q, // target
  input wire logic pop_q, // stack pop
  input wire logic ptr_load_q, // pointer load
  input wire logic tbl_rd_q, // table read
  input wire logic [1:0] tbl_mode_q, // pointer mode
  input wire logic nvm_write_q, // write running
  input wire logic [3:0] bank_select_register_q, // bank
  input wire logic timeout_flag_q, // timeout
  input wire logic powerdown_flag_q, // powerdown
  input wire logic global_interrupt_enable_high_q, // enable
  input wire logic peripheral_interrupt_enable_low_q // enable
);
  logic w2_q;
  logic [15:0] i1_q;
  logic [15:0] i2_q;
  wire take = ce && instr_valid && !busy_q && !w2_q;
  wire w2 = ce && instr_valid && !busy_q && w2_q;
  wire [7:0] cnd = {~flag_n, flag_n, ~flag_ov, flag_ov, ~flag_c, flag_c, ~flag_z, flag_z};
  wire is_br = instr[15:11] == 5'h1c;
  wire is_jmp = instr[15:9] == 7'h76 || instr[15:8] == 8'hef;
  wire is_two = is_jmp || instr[15:6] == 10'h3b8;
  // remember taken words so consequents can look back at operands
  always @(posedge clk) begin
    if (rst)
      w2_q <= 1'b0;
    else if (ce && instr_valid && !busy_q)
      w2_q <= take && is_two;
    if (ce && instr_valid && !busy_q) begin
      i2_q <= i1_q;
      i1_q <= instr;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  br_taken_a:
  assert property (take && is_br && cnd[instr[10:8]] |=> pc_rel_q && busy_q ##1 !busy_q)
    else $error("taken branch timing wrong");
  br_skip_a:
  assert property (take && is_br && !cnd[instr[10:8]] |=> !pc_rel_q && !busy_q)
    else $error("false branch acted");
  jump_words_a:
  assert property (take && is_jmp ##[1:3] w2 && instr[15:12] == 4'hf
    |=> pc_abs_q && pc_abs_addr_q == {i1_q[11:0], i2_q[7:0]} && !busy_q)
    else $error("two word jump wrong");
  stray_word_a:
  assert property (take && instr[15:12] == 4'hf |=> !pc_abs_q && !pc_rel_q && !ptr_load_q)
    else $error("lone second word acted");
  tbl_read_a:
  assert property (take && instr[15:2] == 14'h2
    |=> tbl_rd_q && busy_q && tbl_mode_q == i1_q[1:0] ##1 !busy_q)
    else $error("table read wrong");
  nvm_hold_a:
  assert property (nvm_write_q && !nvm_done |=> nvm_write_q)
    else $error("internal write dropped early");
  standby_flags_a:
  assert property (take && instr == 16'h0003 |=> timeout_flag_q && !powerdown_flag_q)
    else $error("standby flags wrong");
  int_return_a:
  assert property (take && instr[15:1] == 15'h8 |=> pop_q && busy_q
    && global_interrupt_enable_high_q && peripheral_interrupt_enable_low_q)
    else $error("interrupt return wrong");
  bank_load_a:
  assert property (take && instr[15:4] == 12'h010 |=> bank_select_register_q == i1_q[3:0])
    else $error("bank load wrong");
  cover property (take && is_br);
  cover property (nvm_write_q && nvm_done);
  cover property (w2 && instr[15:12] == 4'hf);
endmodule
bind cltd_decoder cltd_decoder_sva cltd_decoder_sva_inst (.*);
`default_nettype wire

// *** bench/cltd_decoder_tb.sv ***
// self-checking bench for the instruction decoder
`timescale 1ns/100ps
`include "cltd_consts.vh"
`default_nettype none
module cltd_decoder_tb;
  logic clk, rst, ce, instr_valid, flag_z, flag_c, flag_ov, flag_n, file_wr, rmw_req;
  logic nvm_done, bus_wr, bus_rd;
  logic [15:0] instr;
  logic [7:0] file_wr_addr, rmw_addr, rmw_latch, port_pins, bus_wdata;
  logic [3:0] bus_addr, lo;
  logic [4:0] msk;
  logic [27:0] lops = 28'hf8b9aed;
  logic [20:0] alus = {`CLTD_ALU_ADD, `CLTD_ALU_SUB, `CLTD_ALU_AND, `CLTD_ALU_IOR,
                       `CLTD_ALU_XOR, `CLTD_ALU_MOV, `CLTD_ALU_MUL};
  wire [7:0] bus_rdata_q, literal_q, rmw_data_q;
  wire busy_q, pc_rel_q, pc_abs_q, push_q, pop_q, fast_q, ptr_load_q, tbl_rd_q, tbl_wr_q;
  wire nvm_write_q, sleep_q, wdt_clr_q, sw_reset_q, timeout_flag_q, powerdown_flag_q;
  wire global_interrupt_enable_high_q, peripheral_interrupt_enable_low_q, prescaler_clr_q;
  wire [10:0] pc_rel_off_q;
  wire [19:0] pc_abs_addr_q;
  wire [4:0] flag_upd_q;
  wire working_register_load_q;
  wire [2:0] alu_op_q;
  wire [3:0] bank_select_register_q;
  wire [1:0] ptr_sel_q, tbl_mode_q;
  wire [11:0] ptr_val_q;
  wire [1:0] en = {global_interrupt_enable_high_q, peripheral_interrupt_enable_low_q};
  int fails, checked, cyc;
  cltd_decoder cltd_decoder_inst (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // offer one word, return in the cycle its effects stand
  task automatic op(input logic [15:0] w);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= w;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata_q, e);
  endtask
  task final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      final_report;
    end
  end
  initial begin
    {rst, ce} = 2'b11;
    {instr_valid, flag_z, flag_c, flag_ov, flag_n, file_wr, rmw_req} = '0;
    {nvm_done, bus_wr, bus_rd, instr, bus_addr} = '0;
    {file_wr_addr, rmw_addr, rmw_latch, port_pins, bus_wdata} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`CLTD_REG_STAT, 8'h0c);
    rd(4'h9, 8'h00);
    // every test once true, once false
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 8; c++) begin
        {flag_n, flag_ov, flag_c, flag_z} <= {4{c[0] == t[0]}};
        op({8'he0 | c[7:0], 8'hfe});
        chk({pc_rel_q, busy_q, pc_rel_off_q}, {{2{t == 0}}, 11'h7fe});
      end
    end
    for (int b = 0; b < 2; b++) begin
      op({4'hd, b[0], 11'h123});
      chk({pc_rel_q, busy_q, push_q, pc_rel_off_q}, {2'b11, b[0], 11'h123});
    end
    op(16'hef12);
    op(16'hf345);
    chk({pc_abs_q, push_q, pc_abs_addr_q}, {2'b10, 20'h34512});
    op(16'hed12);
    op(16'hf345);
    chk({pc_abs_q, push_q, fast_q, pc_abs_addr_q}, {3'b111, 20'h34512});
    op(16'hee2a);
    op(16'hf0bc);
    chk({ptr_load_q, ptr_sel_q, ptr_val_q}, {3'b110, 12'habc});
    op(16'hf0bc);
    chk({ptr_load_q, pc_abs_q, busy_q, pc_rel_q}, 4'h0);
    for (int i = 0; i < 7; i++) begin
      lo = lops[4*i +: 4];
      msk = (lo == 4'hf || lo == 4'h8) ? 5'h1f : (lo > 4'hc ? 5'h00 : 5'h14);
      op({4'h0, lo, 8'h5a});
      chk({flag_upd_q, literal_q, busy_q}, {msk, 8'h5a, 1'b0});
      chk({working_register_load_q, alu_op_q}, {1'b1, alus[3*i +: 3]});
    end
    op(16'h0c77);
    chk({pop_q, busy_q, flag_upd_q, literal_q}, {7'h60, 8'h77});
    chk({working_register_load_q, alu_op_q}, {1'b1, `CLTD_ALU_MOV});
    op(16'h0005);
    chk({push_q, pop_q, busy_q, flag_upd_q}, 8'h80);
    op(16'h0006);
    chk({push_q, pop_q, busy_q, flag_upd_q}, 8'h40);
    // clock enable low: the pop pulse freezes and the offered push is ignored
    ce <= 1'b0;
    op(16'h0005);
    chk({push_q, pop_q, busy_q}, 3'b010);
    ce <= 1'b1;
    op(16'h0105);
    chk(bank_select_register_q, 4'h5);
    op(16'h0011);
    chk({pop_q, busy_q, fast_q, en}, 5'h1f);
    wr(`CLTD_REG_STAT, 8'h00);
    op(16'h0012);
    chk({pop_q, busy_q, fast_q, en}, 5'h18);
    op(16'h0003);
    chk({sleep_q, wdt_clr_q, timeout_flag_q, powerdown_flag_q}, 4'ha);
    op(16'h0004);
    chk({sleep_q, wdt_clr_q, timeout_flag_q, powerdown_flag_q}, 4'h7);
    for (int m = 0; m < 4; m++) begin
      op(16'h0008 | m[15:0]);
      chk({tbl_rd_q, busy_q, tbl_mode_q}, {2'b11, m[1:0]});
    end
    // short write first, then one that starts the internal write
    op(16'h000c);
    chk({tbl_wr_q, busy_q, nvm_write_q}, 3'b110);
    @(posedge clk);
    #1;
    chk(busy_q, 1'b0);
    wr(`CLTD_REG_CTRL, 8'h02);
    op(16'h000d);
    chk({tbl_wr_q, nvm_write_q, busy_q, tbl_mode_q}, 5'h1d);
    repeat (3) @(posedge clk);
    #1;
    chk(busy_q, 1'b1);
    @(posedge clk);
    #1;
    chk({busy_q, nvm_write_q}, 2'b01);
    nvm_done <= 1'b1;
    @(posedge clk);
    nvm_done <= 1'b0;
    #1;
    chk(nvm_write_q, 1'b0);
    wr(`CLTD_REG_CTRL, 8'h01);
    port_pins <= 8'h3c;
    rmw_latch <= 8'hff;
    // timer address then another; port address then another
    for (int k = 0; k < 2; k++) begin
      repeat (8) @(posedge clk);
      file_wr <= 1'b1;
      file_wr_addr <= 8'h01 + k[7:0];
      rmw_req <= 1'b1;
      rmw_addr <= k ? 8'h10 : 8'h81;
      @(posedge clk);
      file_wr <= 1'b0;
      rmw_req <= 1'b0;
      #1;
      chk(prescaler_clr_q, k == 0);
      chk(rmw_data_q, k ? 8'hff : 8'h3c);
    end
    wr(`CLTD_REG_CTRL, 8'h00);
    op(16'h0010);
    op(16'h0003);
    op(16'h00ff);
    chk({sw_reset_q,timeout_flag_q,powerdown_flag_q,en,bank_select_register_q}, 9'h1c0);
    final_report;
  end
endmodule
`default_nettype wire

// *** rtl/cltd_decoder.v ***
// control, literal and table instruction decoder and sequencer
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "cltd_consts.vh"
`default_nettype none

module cltd_decoder (
  input wire clk, // 200 MHz core clock
  input wire rst, // synchronous, active high
  input wire ce, // clock enable, freezes all state
  input wire instr_valid, // instr carries a fetched word
  input wire [15:0] instr, // fetched program word
  input wire flag_z, // zero flag from datapath
  input wire flag_c, // carry flag
  input wire flag_ov, // overflow flag
  input wire flag_n, // negative flag
  input wire file_wr, // datapath writes a file register
  input wire [7:0] file_wr_addr, // its address
  input wire rmw_req, // operand read for read-modify-write
  input wire [7:0] rmw_addr, // operand address
  input wire [7:0] rmw_latch, // output latch value of that register
  input wire [7:0] port_pins, // second port pin levels, asynchronous
  input wire nvm_done, // internal memory write terminated
  input wire [3:0] bus_addr, // register index
  input wire [7:0] bus_wdata, // write data
  input wire bus_wr, // write strobe
  input wire bus_rd, // read strobe
  output reg [7:0] bus_rdata_q, // read data, cycle after strobe
  output reg busy_q, // nop cycle in progress, fetch holds
  output reg pc_rel_q, // add pc_rel_off_q to pc
  output reg [10:0] pc_rel_off_q, // signed word offset
  output reg pc_abs_q, // load pc with pc_abs_addr_q
  output reg [19:0] pc_abs_addr_q, // absolute word address
  output reg push_q, // push return address
  output reg pop_q, // pop return stack
  output reg fast_q, // shadow save/restore with push/pop
  output reg working_register_load_q, // takes alu result
  output reg [2:0] alu_op_q, // alu operation
  output reg [7:0] literal_q, // literal operand
  output reg [4:0] flag_upd_q, // flags to update {n,ov,z,dc,c}
  output reg [3:0] bank_select_register_q, // low bank bits
  output reg ptr_load_q, // load indirect_pointer_register
  output reg [1:0] ptr_sel_q, // which pointer
  output reg [11:0] ptr_val_q, // pointer value
  output reg tbl_rd_q, // table read pulse
  output reg tbl_wr_q, // table write pulse
  output reg [1:0] tbl_mode_q, // none, post inc, post dec, pre inc
  output reg nvm_write_q, // internal write running
  output reg sleep_q, // enter standby
  output reg wdt_clr_q, // clear watchdog
  output reg sw_reset_q, // software device reset
  output reg timeout_flag_q, // timeout flag
  output reg powerdown_flag_q, // powerdown flag
  output reg global_interrupt_enable_high_q, // enable, high
  output reg peripheral_interrupt_enable_low_q, // enable, low
  output reg prescaler_clr_q, // clear timer zero prescaler
  output reg [7:0] rmw_data_q // operand for read-modify-write
);

  reg [1:0] state_q, state_d;
  reg [2:0] cnt_q, cnt_d;
  reg [1:0] w2_kind_q, w2_kind_d;
  reg [8:0] w2_bits_q, w2_bits_d;
  reg [1:0] ctrl_q;
  reg [7:0] tmr_addr_q;
  reg [7:0] port_addr_q;
  reg [7:0] pin_s1_q, pin_s2_q, pin_s3_q, pins_q;
  reg cond;
  reg pc_rel_d, pc_abs_d, push_d, pop_d, fast_d;
  reg [10:0] pc_rel_off_d;
  reg [19:0] pc_abs_addr_d;
  reg working_register_load_d;
  reg [2:0] alu_op_d;
  reg [7:0] literal_d;
  reg [4:0] flag_upd_d;
  reg bank_ld;
  reg ptr_load_d;
  reg [1:0] ptr_sel_d;
  reg [11:0] ptr_val_d;
  reg tbl_rd_d, tbl_wr_d, nvm_start;
  reg [1:0] tbl_mode_d;
  reg sleep_d, wdt_d, swrst_d, intret_d;
  reg [7:0] rd_d;
  wire [7:0] pin_diff;

  // branch test, chosen by the low three bits of the second nibble
  always @* begin
    case (instr[10:8])
      3'h0: cond = flag_z;
      3'h1: cond = ~flag_z;
      3'h2: cond = flag_c;
      3'h3: cond = ~flag_c;
      3'h4: cond = flag_ov;
      3'h5: cond = ~flag_ov;
      3'h6: cond = flag_n;
      3'h7: cond = ~flag_n;
      default: cond = 1'b0;
    endcase
  end

  // main decode; a taken relative jump, branch or return ends in one nop cycle, a two-word call or goto in none
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    w2_kind_d = w2_kind_q;
    w2_bits_d = w2_bits_q;
    pc_rel_d = 1'b0;
    pc_rel_off_d = pc_rel_off_q;
    pc_abs_d = 1'b0;
    pc_abs_addr_d = pc_abs_addr_q;
    push_d = 1'b0;
    pop_d = 1'b0;
    fast_d = 1'b0;
    working_register_load_d = 1'b0;
    alu_op_d = alu_op_q;
    literal_d = literal_q;
    flag_upd_d = `CLTD_FLG_NONE;
    bank_ld = 1'b0;
    ptr_load_d = 1'b0;
    ptr_sel_d = ptr_sel_q;
    ptr_val_d = ptr_val_q;
    tbl_rd_d = 1'b0;
    tbl_wr_d = 1'b0;
    tbl_mode_d = tbl_mode_q;
    nvm_start = 1'b0;
    sleep_d = 1'b0;
    wdt_d = 1'b0;
    swrst_d = 1'b0;
    intret_d = 1'b0;
    case (state_q)
      `CLTD_ST_NOP: begin
        // fetched word is dropped while counting down
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          state_d = `CLTD_ST_EXEC;
        end
      end
      `CLTD_ST_WORD2: begin
        // second word is consumed as operand, not run as nop
        if (instr_valid) begin
          state_d = `CLTD_ST_EXEC;
          case (w2_kind_q)
            `CLTD_W2_CALL: begin
              pc_abs_d = 1'b1;
              push_d = 1'b1;
              fast_d = w2_bits_q[8];
              pc_abs_addr_d = {instr[11:0], w2_bits_q[7:0]};
            end
            `CLTD_W2_GOTO: begin
              pc_abs_d = 1'b1;
              pc_abs_addr_d = {instr[11:0], w2_bits_q[7:0]};
            end
            `CLTD_W2_PTR: begin
              ptr_load_d = 1'b1;
              ptr_val_d = {w2_bits_q[3:0], instr[7:0]};
              ptr_sel_d = w2_bits_q[5:4];
            end
            default: state_d = `CLTD_ST_EXEC;
          endcase
        end
      end
      default: begin
        if (instr_valid) begin
          case (instr[15:12])
            `CLTD_NIB_WORD2: begin
              // lone second word: nothing happens
              state_d = `CLTD_ST_EXEC;
            end
            `CLTD_NIB_REL: begin
              pc_rel_d = 1'b1;
              pc_rel_off_d = instr[10:0];
              push_d = instr[11];
              state_d = `CLTD_ST_NOP;
              cnt_d = `CLTD_NOPS_TWO;
            end
            `CLTD_NIB_BRANCH: begin
              if (instr[11] == 1'b0) begin
                // not taken runs in one cycle
                if (cond) begin
                  pc_rel_d = 1'b1;
                  pc_rel_off_d = {{3{instr[7]}}, instr[7:0]};
                  state_d = `CLTD_ST_NOP;
                  cnt_d = `CLTD_NOPS_TWO;
                end
              end else if (instr[11:9] == `CLTD_SUB_CALL) begin
                state_d = `CLTD_ST_WORD2;
                w2_kind_d = `CLTD_W2_CALL;
                // s rides in bit 8 until the second word arrives
                w2_bits_d = instr[8:0];
              end else if (instr[11:8] == `CLTD_SUB_GOTO) begin
                state_d = `CLTD_ST_WORD2;
                w2_kind_d = `CLTD_W2_GOTO;
                w2_bits_d = instr[8:0];
              end else if (instr[11:8] == `CLTD_SUB_PTR) begin
                state_d = `CLTD_ST_WORD2;
                w2_kind_d = `CLTD_W2_PTR;
                w2_bits_d = instr[8:0];
              end
            end
            `CLTD_NIB_LIT: begin
              literal_d = instr[7:0];
              case (instr[15:8])
                `CLTD_LIT_ADD, `CLTD_LIT_SUB: begin
                  working_register_load_d = 1'b1;
                  alu_op_d = (instr[15:8] == `CLTD_LIT_ADD) ? `CLTD_ALU_ADD : `CLTD_ALU_SUB;
                  flag_upd_d = `CLTD_FLG_ARITH;
                end
                `CLTD_LIT_AND, `CLTD_LIT_IOR, `CLTD_LIT_XOR: begin
                  working_register_load_d = 1'b1;
                  alu_op_d = (instr[9:8] == 2'h3) ? `CLTD_ALU_AND :
                             (instr[9:8] == 2'h1) ? `CLTD_ALU_IOR : `CLTD_ALU_XOR;
                  flag_upd_d = `CLTD_FLG_LOGIC;
                end
                `CLTD_LIT_MOV, `CLTD_LIT_MUL: begin
                  working_register_load_d = 1'b1;
                  alu_op_d = instr[8] ? `CLTD_ALU_MUL : `CLTD_ALU_MOV;
                end
                `CLTD_LIT_RETW: begin
                  working_register_load_d = 1'b1;
                  alu_op_d = `CLTD_ALU_MOV;
                  pop_d = 1'b1;
                  state_d = `CLTD_ST_NOP;
                  cnt_d = `CLTD_NOPS_TWO;
                end
                `CLTD_HI_BANK: begin
                  if (instr[7:4] == 4'h0) begin
                    bank_ld = 1'b1;
                  end
                end
                `CLTD_HI_MISC: begin
                  if (instr[7:0] == `CLTD_OP_SLEEP) begin
                    sleep_d = 1'b1;
                  end else if (instr[7:0] == `CLTD_OP_WDT) begin
                    wdt_d = 1'b1;
                  end else if (instr[7:0] == `CLTD_OP_PUSH) begin
                    push_d = 1'b1;
                  end else if (instr[7:0] == `CLTD_OP_POP) begin
                    pop_d = 1'b1;
                  end else if (instr[7:0] == `CLTD_OP_SWRST) begin
                    swrst_d = 1'b1;
                  end else if (instr[7:1] == `CLTD_OP_RETINT ||
                               instr[7:1] == `CLTD_OP_RETURN) begin
                    pop_d = 1'b1;
                    fast_d = instr[0];
                    intret_d = ~instr[1];
                    state_d = `CLTD_ST_NOP;
                    cnt_d = `CLTD_NOPS_TWO;
                  end else if (instr[7:2] == `CLTD_OP_TAB_RD) begin
                    tbl_rd_d = 1'b1;
                    tbl_mode_d = instr[1:0];
                    state_d = `CLTD_ST_NOP;
                    cnt_d = `CLTD_NOPS_TWO;
                  end else if (instr[7:2] == `CLTD_OP_TAB_WR) begin
                    tbl_wr_d = 1'b1;
                    tbl_mode_d = instr[1:0];
                    state_d = `CLTD_ST_NOP;
                    nvm_start = ctrl_q[`CLTD_CTRL_NVMEN] & ~nvm_write_q;
                    cnt_d = nvm_start ? `CLTD_NOPS_TABLE_WRITE_OP_LONG : `CLTD_NOPS_TWO;
                  end
                end
                default: state_d = `CLTD_ST_EXEC;
              endcase
            end
            default: state_d = `CLTD_ST_EXEC;
          endcase
        end
      end
    endcase
  end

  // register read mux; unmapped indices read zero
  always @* begin
    case (bus_addr)
      `CLTD_REG_CTRL: rd_d = {6'h00, ctrl_q};
      `CLTD_REG_STAT: rd_d = {2'h0, peripheral_interrupt_enable_low_q,
                               global_interrupt_enable_high_q, powerdown_flag_q,
                               timeout_flag_q, nvm_write_q, busy_q};
      `CLTD_REG_BANK: rd_d = {4'h0, bank_select_register_q};
      `CLTD_REG_TMRA: rd_d = tmr_addr_q;
      `CLTD_REG_PORTA: rd_d = port_addr_q;
      default: rd_d = 8'h00;
    endcase
  end

  // a pin bit moves only when the second and third stages agree
  assign pin_diff = pin_s2_q ^ pin_s3_q;

  // sequencer state and pulse outputs
  always @(posedge clk) begin
    if (rst) begin
      state_q <= `CLTD_ST_EXEC;
      cnt_q <= 3'h0;
      w2_kind_q <= `CLTD_W2_CALL;
      w2_bits_q <= 9'h000;
      busy_q <= 1'b0;
      pc_rel_q <= 1'b0;
      pc_rel_off_q <= 11'h000;
      pc_abs_q <= 1'b0;
      pc_abs_addr_q <= 20'h00000;
      push_q <= 1'b0;
      pop_q <= 1'b0;
      fast_q <= 1'b0;
      working_register_load_q <= 1'b0;
      alu_op_q <= `CLTD_ALU_MOV;
      literal_q <= 8'h00;
      flag_upd_q <= `CLTD_FLG_NONE;
      ptr_load_q <= 1'b0;
      ptr_sel_q <= 2'h0;
      ptr_val_q <= 12'h000;
      tbl_rd_q <= 1'b0;
      tbl_wr_q <= 1'b0;
      tbl_mode_q <= 2'h0;
      sleep_q <= 1'b0;
      wdt_clr_q <= 1'b0;
      sw_reset_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      w2_kind_q <= w2_kind_d;
      w2_bits_q <= w2_bits_d;
      busy_q <= (state_d == `CLTD_ST_NOP);
      pc_rel_q <= pc_rel_d;
      pc_rel_off_q <= pc_rel_off_d;
      pc_abs_q <= pc_abs_d;
      pc_abs_addr_q <= pc_abs_addr_d;
      push_q <= push_d;
      pop_q <= pop_d;
      fast_q <= fast_d;
      working_register_load_q <= working_register_load_d;
      alu_op_q <= alu_op_d;
      literal_q <= literal_d;
      flag_upd_q <= flag_upd_d;
      ptr_load_q <= ptr_load_d;
      ptr_sel_q <= ptr_sel_d;
      ptr_val_q <= ptr_val_d;
      tbl_rd_q <= tbl_rd_d;
      tbl_wr_q <= tbl_wr_d;
      tbl_mode_q <= tbl_mode_d;
      sleep_q <= sleep_d;
      wdt_clr_q <= wdt_d;
      sw_reset_q <= swrst_d;
    end
  end

  // status flags; hardware set beats a software write in the same cycle
  always @(posedge clk) begin
    if (rst) begin
      timeout_flag_q <= 1'b1;
      powerdown_flag_q <= 1'b1;
      global_interrupt_enable_high_q <= 1'b0;
      peripheral_interrupt_enable_low_q <= 1'b0;
      bank_select_register_q <= 4'h0;
      nvm_write_q <= 1'b0;
    end else if (ce) begin
      if (swrst_d) begin
        timeout_flag_q <= 1'b1;
        powerdown_flag_q <= 1'b1;
        global_interrupt_enable_high_q <= 1'b0;
        peripheral_interrupt_enable_low_q <= 1'b0;
        bank_select_register_q <= 4'h0;
      end else begin
        if (sleep_d | wdt_d) begin
          timeout_flag_q <= 1'b1;
          powerdown_flag_q <= wdt_d;
        end
        if (intret_d) begin
          global_interrupt_enable_high_q <= 1'b1;
          peripheral_interrupt_enable_low_q <= 1'b1;
        end else if (bus_wr && bus_addr == `CLTD_REG_STAT) begin
          global_interrupt_enable_high_q <= bus_wdata[`CLTD_STAT_ENHI];
          peripheral_interrupt_enable_low_q <= bus_wdata[`CLTD_STAT_ENLO];
        end
        if (bank_ld) begin
          bank_select_register_q <= instr[3:0];
        end else if (bus_wr && bus_addr == `CLTD_REG_BANK) begin
          bank_select_register_q <= bus_wdata[3:0];
        end
      end
      // write keeps running after the instruction until terminated
      if (nvm_start) begin
        nvm_write_q <= 1'b1;
      end else if (nvm_done) begin
        nvm_write_q <= 1'b0;
      end
    end
  end

  // software registers and read data
  always @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `CLTD_RST_CTRL;
      tmr_addr_q <= `CLTD_RST_TMRA;
      port_addr_q <= `CLTD_RST_PORTA;
      bus_rdata_q <= 8'h00;
    end else if (ce) begin
      if (bus_wr && bus_addr == `CLTD_REG_CTRL) begin
        ctrl_q <= bus_wdata[1:0];
      end
      if (bus_wr && bus_addr == `CLTD_REG_TMRA) begin
        tmr_addr_q <= bus_wdata;
      end
      if (bus_wr && bus_addr == `CLTD_REG_PORTA) begin
        port_addr_q <= bus_wdata;
      end
      bus_rdata_q <= bus_rd ? rd_d : 8'h00;
    end
  end

  // pin synchroniser and read-modify-write source
  always @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      pin_s3_q <= 8'h00;
      pins_q <= 8'h00;
      rmw_data_q <= 8'h00;
      prescaler_clr_q <= 1'b0;
    end else if (ce) begin
      pin_s1_q <= port_pins;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pins_q <= (pin_s3_q & ~pin_diff) | (pins_q & pin_diff);
      // latch may differ from a pin held by an outside driver
      if (rmw_req) begin
        rmw_data_q <= (rmw_addr == port_addr_q) ? pins_q : rmw_latch;
      end
      prescaler_clr_q <= file_wr && (file_wr_addr == tmr_addr_q) &&
                         ctrl_q[`CLTD_CTRL_PSA];
    end
  end

endmodule

`default_nettype wire

// *** shared/cltd_consts.vh ***
// constants for the control, literal and table instruction decoder
`ifndef CLTD_CONSTS_VH
`define CLTD_CONSTS_VH

// decoder states
`define CLTD_ST_EXEC 2'h0
`define CLTD_ST_WORD2 2'h1
`define CLTD_ST_NOP 2'h2

// pending second-word kinds
`define CLTD_W2_CALL 2'h0
`define CLTD_W2_GOTO 2'h1
`define CLTD_W2_PTR 2'h2

// nop cycles appended after the executing cycle
`define CLTD_NOPS_TWO 3'h1
`define CLTD_NOPS_TABLE_WRITE_OP_LONG 3'h4

// opcode fields
`define CLTD_NIB_BRANCH 4'he
`define CLTD_NIB_REL 4'hd
`define CLTD_NIB_WORD2 4'hf
`define CLTD_NIB_LIT 4'h0
`define CLTD_SUB_CALL 3'h6
`define CLTD_SUB_GOTO 4'hf
`define CLTD_SUB_PTR 4'he
`define CLTD_HI_MISC 8'h00
`define CLTD_HI_BANK 8'h01
`define CLTD_LIT_ADD 8'h0f
`define CLTD_LIT_SUB 8'h08
`define CLTD_LIT_AND 8'h0b
`define CLTD_LIT_IOR 8'h09
`define CLTD_LIT_XOR 8'h0a
`define CLTD_LIT_MOV 8'h0e
`define CLTD_LIT_MUL 8'h0d
`define CLTD_LIT_RETW 8'h0c

// misc opcodes, low byte with high byte zero
`define CLTD_OP_SLEEP 8'h03
`define CLTD_OP_WDT 8'h04
`define CLTD_OP_PUSH 8'h05
`define CLTD_OP_POP 8'h06
`define CLTD_OP_SWRST 8'hff
`define CLTD_OP_RETINT 7'h08
`define CLTD_OP_RETURN 7'h09
`define CLTD_OP_TAB_RD 6'h02
`define CLTD_OP_TAB_WR 6'h03

// alu operation codes
`define CLTD_ALU_ADD 3'h0
`define CLTD_ALU_SUB 3'h1
`define CLTD_ALU_AND 3'h2
`define CLTD_ALU_IOR 3'h3
`define CLTD_ALU_XOR 3'h4
`define CLTD_ALU_MOV 3'h5
`define CLTD_ALU_MUL 3'h6

// flag update masks {n, ov, z, dc, c}
`define CLTD_FLG_NONE 5'h00
`define CLTD_FLG_ARITH 5'h1f
`define CLTD_FLG_LOGIC 5'h14

// register map, word indices on the plain port
`define CLTD_REG_CTRL 4'h0
`define CLTD_REG_STAT 4'h1
`define CLTD_REG_BANK 4'h2
`define CLTD_REG_TMRA 4'h3
`define CLTD_REG_PORTA 4'h4

// field positions
`define CLTD_CTRL_PSA 0
`define CLTD_CTRL_NVMEN 1
`define CLTD_STAT_BUSY 0
`define CLTD_STAT_NVM 1
`define CLTD_STAT_TMOUT 2
`define CLTD_STAT_PWRDN 3
`define CLTD_STAT_ENHI 4
`define CLTD_STAT_ENLO 5

// reset values
`define CLTD_RST_CTRL 2'h0
`define CLTD_RST_TMRA 8'h01
`define CLTD_RST_PORTA 8'h81

`endif
